/* File: rtl/rqff_pkg.sv */
// constants and carriers for the receive queue frame formatter
// assumes one system clock shared by mac side, formatter and bus
package rqff_pkg;

  // =====================================================================
  // queue geometry and frame limits
  localparam int unsigned QUEUE_BYTES     = 4096;
  localparam int unsigned DATA_MAX_BYTES  = 1916;
  localparam int unsigned LEN_TYPE_LIMIT  = 1500;
  localparam int unsigned MAX_FRAME_BYTES = 1518;
  localparam int unsigned FCS_BYTES       = 4;
  localparam int unsigned DA_BYTES        = 6;
  localparam int unsigned TYPE_HI_IDX     = 12;
  localparam int unsigned TYPE_LO_IDX     = 13;

  // =====================================================================
  // frame entry layout, byte offsets inside one entry
  localparam int unsigned STATUS_OFFSET = 0;
  localparam int unsigned COUNT_OFFSET  = 2;
  localparam int unsigned DATA_OFFSET   = 4;
  localparam int unsigned HDR_WORDS     = DATA_OFFSET / 2;

  // =====================================================================
  // status word fields
  localparam int unsigned ST_VALID_BIT = 15;
  localparam int unsigned ST_PORT_LSB  = 8;
  localparam int unsigned ST_BCAST_BIT = 7;
  localparam int unsigned ST_MCAST_BIT = 6;
  localparam int unsigned ST_UCAST_BIT = 5;
  localparam int unsigned ST_ETYPE_BIT = 3;
  localparam int unsigned ST_LONG_BIT  = 2;
  localparam int unsigned ST_RUNT_BIT  = 1;
  localparam int unsigned ST_CRC_BIT   = 0;
  localparam logic [15:0] ST_RESV_MASK = 16'h7c10;
  localparam logic [1:0]  PORT1_CODE   = 2'h1;
  localparam logic [1:0]  PORT2_CODE   = 2'h2;
  localparam int unsigned CNT_BITS     = 11;
  localparam logic [7:0]  BCAST_BYTE   = 8'hff;

  // =====================================================================
  // register map, byte addresses on the bus
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_COUNT   = 8'h08;
  localparam logic [7:0] REG_DATA    = 8'h0c;
  localparam logic [7:0] REG_RELEASE = 8'h10;
  localparam logic [7:0] REG_DROPS   = 8'h14;
  localparam int unsigned CTRL_STRIP_BIT = 0;
  localparam int unsigned CTRL_PASS_BIT  = 1;
  localparam int unsigned RELEASE_BIT    = 0;
  localparam logic        CTRL_STRIP_RST = 1'b0;
  localparam logic        CTRL_PASS_RST  = 1'b0;

  // one received byte from the mac side
  typedef struct packed {
    logic       sop;
    logic       eop;
    logic [7:0] data;
    logic       port_sel;
    logic       crc_err;
    logic       runt;
  } rqff_beat_s;

endpackage

/* File: rtl/rqff_top.sv */
// receive queue frame formatter: stores mac frames with a header
// assumes mac side logic on clk and a classic wishbone master
// Notes on behaviour
// [RULE1] status word sits at entry offset 0
// [RULE2] byte count word sits at offset 2
// [RULE3] packet data from offset 4, max 1916
// [RULE4] fcs kept only when stripping is off
// [RULE5] status register shows current frame status
// [RULE6] valid bit only for complete stored frame
// [RULE7] valid clear while none pending or receiving
// [RULE8] port field 01 port one, 10 two
// [RULE9] broadcast destination sets bit 7
// [RULE10] multicast sets bit 6, broadcast included
// [RULE11] unicast destination sets bit 5
// [RULE12] length/type above 1500 sets bit 3
// [RULE13] host ignores frame type on runts
// [RULE14] frame above 1518 bytes sets bit 2
// [RULE15] long frames flagged, never truncated
// [RULE16] collision or early end sets bit 1
// [RULE17] crc error sets bit 0
// [RULE18] bad frames dropped unless pass enabled
// [RULE19] count in bits 10-0, rest reserved
// [RULE20] 4KB queue holds frames back to back
// [RULE21] reserved header bits written as zero
// [RULE22] valid status written after count and data
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module rqff_top #(
  parameter int unsigned QBYTES = rqff_pkg::QUEUE_BYTES,
  parameter int unsigned DMAX   = rqff_pkg::DATA_MAX_BYTES
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [31:0]         wb_dat_i,
  input  wire logic [3:0]          wb_sel_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                rx_valid,
  input  wire rqff_pkg::rqff_beat_s rx_beat,
  output logic                     rx_ready
);
  import rqff_pkg::*;

  localparam int unsigned DEPTH = QBYTES / 2;
  localparam int unsigned AW    = $clog2(DEPTH);

  // =====================================================================
  // elaboration checks
  generate
    if ((1 << AW) != DEPTH || QBYTES < 8)
      $error("queue size must be a power of two bytes");
    if (DMAX + DATA_OFFSET > QBYTES || DMAX >= (1 << CNT_BITS))
      $error("data limit does not fit queue or count field");
  endgenerate

  typedef logic [AW:0]          rqff_ptr_t;
  typedef logic [CNT_BITS-1:0]  rqff_cnt_t;
  typedef enum logic [1:0] {ST_RECV_IDLE, ST_RECV, ST_HDR_CNT, ST_HDR_STAT}
    rqff_state_e;

  typedef struct packed {
    logic [DEPTH-1:0][15:0] mem;
    rqff_state_e            st;
    rqff_ptr_t              wr;
    rqff_ptr_t              rd_base;
    rqff_ptr_t              rd_ptr;
    rqff_cnt_t              nbytes;
    logic [7:0]             hold;
    logic [15:0]            lentype;
    logic                   bcast;
    logic                   mcast;
    logic                   port_sel;
    logic                   crc_err;
    logic                   runt;
    logic                   ovf;
    logic                   strip;
    logic                   pass_bad;
    logic [15:0]            drop_cnt;
    logic                   ready;
    logic                   ack;
    logic [31:0]            dat_o;
  } rqff_state_s;

  rqff_state_s s;
  rqff_state_s next_s;

  // =====================================================================
  // helpers
  function automatic logic [AW-1:0] slot(input rqff_ptr_t p);
    return p[AW-1:0];
  endfunction

  function automatic rqff_ptr_t words_of(input rqff_cnt_t c);
    return rqff_ptr_t'((c + rqff_cnt_t'(1)) >> 1);
  endfunction

  // count stored for the host, fcs removed when stripping
  function automatic rqff_cnt_t host_count(input rqff_cnt_t n,
                                           input logic strip);
    if (strip && n >= rqff_cnt_t'(FCS_BYTES))                   // [RULE4]
      return n - rqff_cnt_t'(FCS_BYTES);
    return n;
  endfunction

  function automatic logic too_long(input rqff_cnt_t n);
    return n > rqff_cnt_t'(MAX_FRAME_BYTES);
  endfunction

  wire logic pending = (s.rd_base != s.wr);
  wire logic bad     = too_long(s.nbytes) || s.runt || s.crc_err;

  // =====================================================================
  // next state
  always_comb begin
    logic [15:0] stw;
    rqff_ptr_t   dp;
    rqff_cnt_t   idx;
    rqff_cnt_t   cnt;
    logic        take;
    logic        req;
    stw    = '0;
    dp     = '0;
    idx    = '0;
    cnt    = host_count(s.nbytes, s.strip);
    take   = rx_valid && s.ready;
    req    = wb_cyc_i && wb_stb_i && !s.ack;
    next_s = s;
    next_s.ack = 1'b0;

    case (s.st)
      ST_RECV_IDLE: begin
        if (take && rx_beat.sop) begin
          next_s.st      = ST_RECV;
          next_s.nbytes  = '0;
          next_s.bcast   = 1'b1;
          next_s.mcast   = 1'b0;
          next_s.lentype = '0;
          next_s.crc_err = 1'b0;
          next_s.runt    = 1'b0;
          next_s.port_sel = rx_beat.port_sel;
          // header slots must fit before any byte is taken
          next_s.ovf = (s.wr - s.rd_base) >
                       rqff_ptr_t'(DEPTH - HDR_WORDS);
        end
      end
      ST_HDR_CNT: begin
        if (s.ovf || (bad && !s.pass_bad)) begin                 // [RULE18]
          next_s.drop_cnt = s.drop_cnt + 16'h0001;
          next_s.st       = ST_RECV_IDLE;
        end else begin
          // upper count bits stay zero                  [RULE19] [RULE21]
          next_s.mem[slot(s.wr + rqff_ptr_t'(COUNT_OFFSET / 2))] =
            {{(16-CNT_BITS){1'b0}}, cnt};                         // [RULE2]
          // odd count: blank the upper byte, it may hold a stripped fcs byte
          if (cnt[0])
            next_s.mem[slot(s.wr + rqff_ptr_t'(HDR_WORDS) +
                            rqff_ptr_t'(cnt >> 1))][15:8] = 8'h00;  // [RULE4]
          next_s.st = ST_HDR_STAT;
        end
      end
      ST_HDR_STAT: begin
        stw[ST_VALID_BIT] = 1'b1;                                 // [RULE6]
        stw[ST_PORT_LSB +: 2] =
          s.port_sel ? PORT2_CODE : PORT1_CODE;                   // [RULE8]
        stw[ST_BCAST_BIT] = s.bcast;                              // [RULE9]
        stw[ST_MCAST_BIT] = s.mcast || s.bcast;                   // [RULE10]
        stw[ST_UCAST_BIT] = !(s.mcast || s.bcast);                // [RULE11]
        // meaningless on runts, host must ignore it
        stw[ST_ETYPE_BIT] = s.lentype > 16'(LEN_TYPE_LIMIT);      // [RULE12]
        stw[ST_LONG_BIT]  = too_long(s.nbytes);                   // [RULE14]
        stw[ST_RUNT_BIT]  = s.runt;                               // [RULE16]
        stw[ST_CRC_BIT]   = s.crc_err;                            // [RULE17]
        // written last, so valid implies count and data are in [RULE22]
        next_s.mem[slot(s.wr + rqff_ptr_t'(STATUS_OFFSET / 2))] =
          stw;                                                    // [RULE1]
        // step by the stored count, so a strip change here cannot skew it
        next_s.wr = s.wr + rqff_ptr_t'(HDR_WORDS) +
          words_of(s.mem[slot(s.wr + rqff_ptr_t'(COUNT_OFFSET / 2))]
                   [CNT_BITS-1:0]);                               // [RULE20]
        next_s.st = ST_RECV_IDLE;
      end
      default: ;
    endcase

    // byte path, shared by the first byte and the rest
    if (take && (s.st == ST_RECV ||
                 (s.st == ST_RECV_IDLE && rx_beat.sop))) begin
      idx = next_s.nbytes;
      dp  = s.wr + rqff_ptr_t'(HDR_WORDS) + rqff_ptr_t'(idx >> 1); // [RULE3]
      if (idx == '0)
        next_s.mcast = rx_beat.data[0];
      if (idx < rqff_cnt_t'(DA_BYTES) && rx_beat.data != BCAST_BYTE)
        next_s.bcast = 1'b0;
      if (idx == rqff_cnt_t'(TYPE_HI_IDX))
        next_s.lentype[15:8] = rx_beat.data;
      if (idx == rqff_cnt_t'(TYPE_LO_IDX))
        next_s.lentype[7:0] = rx_beat.data;
      // no truncation: a frame that does not fit is dropped whole
      if (idx >= rqff_cnt_t'(DMAX) ||                            // [RULE15]
          (dp - s.rd_base) >= rqff_ptr_t'(DEPTH))
        next_s.ovf = 1'b1;
      else if (!idx[0] && !rx_beat.eop)
        next_s.hold = rx_beat.data;
      else if (!idx[0])
        next_s.mem[slot(dp)] = {8'h00, rx_beat.data};
      else
        next_s.mem[slot(dp)] = {rx_beat.data, s.hold};
      if (idx != '1)
        next_s.nbytes = idx + rqff_cnt_t'(1);
      next_s.crc_err = next_s.crc_err || rx_beat.crc_err;
      next_s.runt    = next_s.runt || rx_beat.runt;
      if (rx_beat.eop)
        next_s.st = ST_HDR_CNT;
    end

    // =====================================================================
    // wishbone slave, one wait state, unmapped reads give zero
    if (req) begin
      next_s.ack   = 1'b1;
      next_s.dat_o = '0;
      if (wb_we_i) begin
        if (wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
          next_s.strip    = wb_dat_i[CTRL_STRIP_BIT];
          next_s.pass_bad = wb_dat_i[CTRL_PASS_BIT];
        end
        if (wb_adr_i == REG_RELEASE && wb_sel_i[0] &&
            wb_dat_i[RELEASE_BIT] && pending) begin
          next_s.rd_base = s.rd_base + rqff_ptr_t'(HDR_WORDS) +
            words_of(s.mem[slot(s.rd_base + rqff_ptr_t'(1))][CNT_BITS-1:0]);
          next_s.rd_ptr = next_s.rd_base;
        end
      end else begin
        case (wb_adr_i)
          REG_CTRL: begin
            next_s.dat_o[CTRL_STRIP_BIT] = s.strip;
            next_s.dat_o[CTRL_PASS_BIT]  = s.pass_bad;
          end
          REG_STATUS: begin
            // zero while nothing complete is queued   [RULE5] [RULE7]
            if (pending)
              next_s.dat_o[15:0] = s.mem[slot(s.rd_base)];
          end
          REG_COUNT: begin
            if (pending)
              next_s.dat_o[15:0] =
                s.mem[slot(s.rd_base + rqff_ptr_t'(1))];
          end
          REG_DATA: begin
            if (pending) begin
              next_s.dat_o[15:0] = s.mem[slot(s.rd_ptr)];
              next_s.rd_ptr      = s.rd_ptr + rqff_ptr_t'(1);
            end
          end
          REG_DROPS: next_s.dat_o[15:0] = s.drop_cnt;
          default:   next_s.dat_o = '0;
        endcase
      end
    end

    next_s.ready = (next_s.st == ST_RECV_IDLE) || (next_s.st == ST_RECV);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s          <= '0;
      s.strip    <= CTRL_STRIP_RST;
      s.pass_bad <= CTRL_PASS_RST;
    end else begin
      s <= next_s;
    end
  end

  assign wb_dat_o = s.dat_o;
  assign wb_ack_o = s.ack;
  assign rx_ready = s.ready;

  // =====================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence hdr_seq;
    s.st == ST_HDR_CNT ##1 s.st == ST_HDR_STAT;
  endsequence

  chk_hdr_order: assert property (                               // [RULE22]
    s.st == ST_HDR_CNT && !(s.ovf || (bad && !s.pass_bad))
    |=> s.st == ST_HDR_STAT && !s.ready)
    else $error("count must be followed by status");

  chk_wr_commit: assert property (                               // [RULE22]
    $changed(s.wr) |-> $past(s.st) == ST_HDR_STAT)
    else $error("write pointer moved outside commit");

  chk_valid_set: assert property (                               // [RULE6]
    hdr_seq |=> s.mem[slot($past(s.wr))][ST_VALID_BIT] && pending)
    else $error("committed status lacks valid bit");

  chk_bcast_mcast: assert property (                             // [RULE10]
    hdr_seq |=> !s.mem[slot($past(s.wr))][ST_BCAST_BIT] ||
                 s.mem[slot($past(s.wr))][ST_MCAST_BIT])
    else $error("broadcast without multicast");

  chk_resv_zero: assert property (                               // [RULE21]
    hdr_seq |=> (s.mem[slot($past(s.wr))] & ST_RESV_MASK) == '0)
    else $error("reserved status bits not zero");

  chk_port_code: assert property (                               // [RULE8]
    hdr_seq |=> s.mem[slot($past(s.wr))][ST_PORT_LSB +: 2] inside
                {PORT1_CODE, PORT2_CODE})
    else $error("invalid port encoding");

  chk_long_flag: assert property (                               // [RULE14]
    hdr_seq |=> s.mem[slot($past(s.wr))][ST_LONG_BIT] ==
                ($past(s.nbytes, 2) > rqff_cnt_t'(MAX_FRAME_BYTES)))
    else $error("too long flag wrong");

  chk_strip_cnt: assert property (                               // [RULE4]
    s.st == ST_HDR_CNT && s.strip && !s.ovf && !(bad && !s.pass_bad) &&
    s.nbytes >= rqff_cnt_t'(FCS_BYTES)
    |=> s.mem[slot(s.wr + rqff_ptr_t'(1))] ==
        16'($past(s.nbytes) - rqff_cnt_t'(FCS_BYTES)))
    else $error("stripped count wrong");

  chk_bad_drop: assert property (                                // [RULE18]
    s.st == ST_HDR_CNT && bad && !s.pass_bad
    |=> s.st == ST_RECV_IDLE ##1 $stable(s.wr))
    else $error("bad frame not dropped");

  chk_idle_status: assert property (                             // [RULE7]
    s.ack && !pending && $past(wb_adr_i) == REG_STATUS && !$past(wb_we_i)
    |-> s.dat_o == '0)
    else $error("status read nonzero with nothing pending");

  chk_ack_pulse: assert property (
    s.ack |=> !s.ack)
    else $error("ack held longer than one cycle");

endmodule

`default_nettype wire

/* File: verification/rqff_mac_src.sv */
// mac receive side model: streams one frame of bytes into the formatter
// assumes the bench fills fbytes and calls send after a rising edge
`timescale 1ns/1ps
`default_nettype none

module rqff_mac_src
  import rqff_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rx_ready,
  output var  logic       rx_valid,
  output var  rqff_beat_s rx_beat
);
  logic [7:0] fbytes [$];
  logic       stuck;

  initial begin
    rx_valid = 1'b0;
    rx_beat  = '0;
    stuck    = 1'b0;
  end

  // =====================================================================
  // frame transfer
  // each byte held until sampled with ready high; flags only on eop
  task automatic send(input logic p, input logic c, input logic r);
    int n;
    logic last;
    for (int i = 0; i < fbytes.size(); i++) begin
      last = (i == fbytes.size() - 1);
      rx_valid <= 1'b1;
      rx_beat  <= '{i == 0, last, fbytes[i], p, c & last, r & last};
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (rx_ready !== 1'b1 && n < 1000);
      if (n >= 1000) begin
        stuck = 1'b1;
        break;
      end
    end
    rx_valid <= 1'b0;
    // idle lines show a changed pattern, not the last byte
    rx_beat  <= rqff_beat_s'(~rx_beat);
    // one idle edge so a following frame never re-drives in this step
    @(posedge clk);
  endtask
endmodule

`default_nettype wire

/* File: verification/rx_queue_frame_formatter_tb.sv */
// bench for the receive queue formatter: mac model plus wishbone host
// assumes the default queue geometry; the bus answers with ack
`timescale 1ns/1ps
`default_nettype none

module rx_queue_frame_formatter_tb;
  import rqff_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [31:0] wb_wdat;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        rx_valid;
  logic        rx_ready;
  rqff_beat_s  rx_beat;
  int          fails;
  int          cmp_count;
  int          drops_e;
  int          lens [3] = '{1523, 1519, 1521};
  logic [31:0] q;

  rqff_top dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_dat_i(wb_wdat), .wb_sel_i(4'hf), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .rx_valid(rx_valid), .rx_beat(rx_beat),
    .rx_ready(rx_ready));

  rqff_mac_src mac_u (.clk(clk), .rx_ready(rx_ready),
    .rx_valid(rx_valid), .rx_beat(rx_beat));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // =====================================================================
  // reporting
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // =====================================================================
  // bus cycles
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= a;
    wb_wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      wrap_up();
    end
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    wb(1'b0, a, 32'h0, r);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  // =====================================================================
  // frames and expectations
  // da kind: 0 unicast, 1 multicast, 2 broadcast
  task automatic mk(input int len, input int da, input logic [15:0] lt);
    mac_u.fbytes.delete();
    repeat (len) mac_u.fbytes.push_back(8'($urandom));
    for (int i = 0; i < 6; i++)
      if (da == 2) mac_u.fbytes[i] = 8'hff;
    if (da != 2) mac_u.fbytes[0] = (da == 1) ? 8'h01 : 8'h02;
    mac_u.fbytes[12] = lt[15:8];
    mac_u.fbytes[13] = lt[7:0];
  endtask

  task automatic tx(input logic p, input logic c, input logic r);
    mac_u.send(p, c, r);
    if (mac_u.stuck) begin
      fails++;
      wrap_up();
    end
  endtask

  function automatic logic [15:0] est(logic p, int da, logic [15:0] lt,
                                      int len, logic c, logic r);
    est = 16'h8000;
    est[9:8] = p ? 2'b10 : 2'b01;
    est[7] = (da == 2);
    est[6] = (da != 0);
    est[5] = (da == 0);
    est[3] = (lt > 16'd1500);
    est[2] = (len > 1518);
    est[1] = r;
    est[0] = c;
  endfunction

  // waits for the head frame, checks header and data, then frees it
  task automatic take(input logic p, input int da, input logic [15:0] lt,
                      input logic s, input logic c, input logic r);
    int len;
    int cnt;
    int n;
    logic [15:0] e;
    logic [15:0] m;
    logic [7:0] hi;
    logic [31:0] v;
    len = mac_u.fbytes.size();
    cnt = s ? len - 4 : len;
    e = est(p, da, lt, len, c, r);
    m = r ? 16'hfff7 : 16'hffff;
    n = 0;
    do begin
      rd(8'h04, v);
      n++;
    end while (v[15] !== 1'b1 && n < 10);
    chk("status", v & m, {16'h0, e & m});
    rd(8'h08, v);
    chk("count", v, {21'h0, cnt[10:0]});
    rd(8'h0c, v);
    chk("word0", v & m, {16'h0, e & m});
    rd(8'h0c, v);
    chk("word1", v, {21'h0, cnt[10:0]});
    for (int j = 0; j < (cnt + 1) / 2; j++) begin
      hi = (2 * j + 1 < cnt) ? mac_u.fbytes[2 * j + 1] : 8'h00;
      rd(8'h0c, v);
      chk("data", v, {16'h0, hi, mac_u.fbytes[2 * j]});
    end
    wr(8'h10, 32'h1);
  endtask

  task automatic dropped();
    logic [31:0] v;
    repeat (3) @(posedge clk);
    drops_e++;
    rd(8'h14, v);
    chk("drops", v, 32'(drops_e));
  endtask

  // =====================================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h0;
    wb_wdat = 32'h0;
    fails = 0;
    cmp_count = 0;
    drops_e = 0;
    void'($urandom(32'hddd09d78));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h00, q);
    chk("ctrl", q, 32'h0);
    rd(8'h04, q);
    chk("status", q, 32'h0);
    rd(8'h0c, q);
    chk("data", q, 32'h0);
    rd(8'h1c, q);
    chk("unmapped", q, 32'h0);
    $display("test reset done");
    // every address class, both ports, strip on and off, type boundary
    for (int k = 0; k < 12; k++) begin
      wr(8'h00, {31'h0, k[0]});
      mk(14 + $urandom % 50, k % 3, (k >= 6) ? 16'd1501 : 16'd1500);
      tx(k[1], 1'b0, 1'b0);
      take(k[1], k % 3, (k >= 6) ? 16'd1501 : 16'd1500, k[0], 1'b0, 1'b0);
    end
    $display("test good frames done");
    for (int b = 0; b < 4; b++) begin
      wr(8'h00, {30'h0, b[1], 1'b0});
      mk(20 + $urandom % 30, 1, 16'h0800);
      tx(1'b0, b[0], ~b[0]);
      if (b[1]) take(1'b0, 1, 16'h0800, 1'b0, b[0], ~b[0]);
      else dropped();
      rd(8'h04, q);
      chk("status", q, 32'h0);
    end
    $display("test bad frames done");
    wr(8'h00, 32'h2);
    mk(1520, 0, 16'h0800);
    fork
      tx(1'b1, 1'b0, 1'b0);
      begin
        repeat (100) @(posedge clk);
        rd(8'h04, q);
        chk("status busy", q, 32'h0);
      end
    join
    take(1'b1, 0, 16'h0800, 1'b0, 1'b0, 1'b0);
    wr(8'h00, 32'h0);
    tx(1'b1, 1'b0, 1'b0);
    dropped();
    $display("test long frames done");
    wr(8'h00, 32'h2);
    for (int k = 0; k < 3; k++) begin
      mk(lens[k], 2, 16'h0800);
      tx(1'b0, 1'b0, 1'b0);
    end
    dropped();
    rd(8'h08, q);
    chk("count head", q, 32'd1523);
    wr(8'h10, 32'h1);
    rd(8'h08, q);
    chk("count next", q, 32'd1519);
    wr(8'h10, 32'h1);
    rd(8'h04, q);
    chk("status empty", q, 32'h0);
    $display("test queue full done");
    wrap_up();
  end
endmodule

`default_nettype wire
